// ### dv/ddi_decoder_checker.sv
// Port assertions for the digital input decoder
`timescale 1ns/1ps
`default_nettype none
`include "ddi_regs.svh"
module ddi_decoder_checker (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [5:0] digital_input,
  input wire logic speed_zero,
  input wire logic fault_event,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire ddi_pkg::ddi_cmd_type cmd,
  input wire logic [7:0] output_select,
  input wire logic [15:0] reference_one_floor,
  input wire logic [15:0] reference_one_ceiling
);
  import ddi_pkg::*;
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  chk_outsel_running: assert property (
    reg_wr && reg_addr == `DDI_OFS_OUTSEL && cmd.run |=> $stable(output_select))
    else $error("output select changed while running");
  chk_lock_blocks: assert property (
    reg_wr && reg_addr == `DDI_OFS_SCALE && cmd.param_lock
    |=> $stable({reference_one_ceiling, reference_one_floor}))
    else $error("scale changed while locked");
  chk_scale_refuse: assert property (
    reg_wr && reg_addr == `DDI_OFS_SCALE && reg_wdata[15:0] > reg_wdata[31:16]
    |=> $stable({reference_one_ceiling, reference_one_floor}))
    else $error("inverted scale accepted");
  chk_scale_accept: assert property (
    reg_wr && reg_addr == `DDI_OFS_SCALE && !cmd.param_lock
    && reg_wdata[15:0] <= reg_wdata[31:16]
    |=> {reference_one_ceiling, reference_one_floor} == $past(reg_wdata))
    else $error("valid scale not taken");
  chk_scale_order: assert property (
    reference_one_floor <= reference_one_ceiling)
    else $error("floor above ceiling");
  chk_coast_run: assert property (
    cmd.coast_stop |-> !cmd.run)
    else $error("running while run enable low");
  chk_fault_sets: assert property (
    fault_event |-> ##[1:2] cmd.fault)
    else $error("fault flag not set");
  chk_reset_pulse: assert property (
    cmd.fault_reset |=> !cmd.fault_reset)
    else $error("fault reset longer than one cycle");
  chk_rdata_idle: assert property (
    !$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside read slot");
  // ----------------------------------------------------------------
  // Cover points
  // ----------------------------------------------------------------
  cov_run: cover property ($rose(cmd.run));
  cov_reset: cover property (cmd.fault_reset);
  cov_speed7: cover property (cmd.const_speed == 3'h7);
endmodule : ddi_decoder_checker
bind ddi_decoder ddi_decoder_checker chk (.*);
`default_nettype wire

// ### dv/ddi_switches.sv
// Operator switch model driving the six digital inputs
`timescale 1ns/1ps
`default_nettype none
module ddi_switches (
  input wire logic core_clk,
  output logic [5:0] digital_input
);
  // All switches open at power up
  initial digital_input = 6'h00;
  // Sets every switch level after an edge
  task automatic set_pins(input logic [5:0] v);
    @(posedge core_clk);
    digital_input <= v;
  endtask : set_pins
  task automatic pulse(input int i, input logic v);
    @(posedge core_clk);
    digital_input[i] <= v;
    repeat (4) @(posedge core_clk);
    digital_input[i] <= ~v;
    @(negedge core_clk);
  endtask : pulse
endmodule : ddi_switches
`default_nettype wire

// ### dv/tb.sv
// Self-checking bench for the digital input decoder
`timescale 1ns/1ps
`default_nettype none
`include "ddi_regs.svh"
module tb;
  import ddi_pkg::*;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic [5:0] digital_input;
  logic speed_zero = 1'b0;
  logic fault_event = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  ddi_cmd_type cmd;
  logic [7:0] output_select;
  logic [15:0] reference_one_floor;
  logic [15:0] reference_one_ceiling;
  int num_errors = 0;
  int checked = 0;
  int cycles = 0;
  logic [31:0] rv;
  wire logic [31:0] run_rev = 32'({cmd.run, cmd.reverse});
  wire logic [31:0] scale_now = {reference_one_ceiling, reference_one_floor};
  // Constant speed table: selection, pins, expected speed
  logic [3:0] cs_sel [7] = '{4'h4, 4'h2, 4'h8, 4'h9, 4'hC, 4'hA, 4'hB};
  logic [5:0] cs_pin [7] = '{6'h08, 6'h00, 6'h08, 6'h10, 6'h28, 6'h07, 6'h04};
  logic [2:0] cs_exp [7] = '{3'h4, 3'h0, 3'h2, 3'h1, 3'h5, 3'h7, 3'h1};
  // ----------------------------------------------------------------
  // Clock, partner, design
  // ----------------------------------------------------------------
  always #12.5 core_clk = ~core_clk;
  ddi_switches sw (.*);
  ddi_decoder #(.POT_TICK_CYCLES(4)) dut (.*);
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic final_report;
    $display("Errors %0d of %0d comparisons", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : final_report
  // Cuts a hung run short
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      final_report();
    end
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    repeat (2) @(negedge core_clk);
  endtask : wr
  // Read data are taken in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    d = reg_rdata;
  endtask : rd
  // Compares a settled value away from the clock edge
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic pins(input logic [5:0] v);
    sw.set_pins(v);
    repeat (6) @(negedge core_clk);
  endtask : pins
  task automatic fault;
    @(posedge core_clk);
    fault_event <= 1'b1;
    @(posedge core_clk);
    fault_event <= 1'b0;
    @(negedge core_clk);
  endtask : fault
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(posedge core_clk);
    resetn <= 1'b1;
    rd(`DDI_OFS_CTRL, rv); chk(rv, 32'h22); // level mode default
    rd(8'h20, rv); chk(rv, 32'h0); // unmapped reads zero
    pins(6'h01); chk(run_rev, 32'h2); // run forward
    pins(6'h03); chk(run_rev, 32'h3); // run reverse
    wr(`DDI_OFS_OUTSEL, 32'h5A); chk(32'(output_select), 32'h0); // refused
    pins(6'h00); chk(32'(cmd.run), 32'h0); // stop
    wr(`DDI_OFS_OUTSEL, 32'h5A); chk(32'(output_select), 32'h5A); // taken
    wr(`DDI_OFS_CTRL, 32'h23); pins(6'h02);
    sw.pulse(0, 1'b1); chk(32'(cmd.run), 32'h1); // start held
    sw.pulse(1, 1'b0); chk(32'(cmd.run), 32'h0); // stop
    pins(6'h00); sw.pulse(0, 1'b1); pins(6'h02); chk(32'(cmd.run), 32'h0); // ignored
    wr(`DDI_OFS_CTRL, 32'h24); pins(6'h06);
    sw.pulse(0, 1'b1); chk(run_rev, 32'h3); // reverse level
    wr(`DDI_OFS_CTRL, 32'h25); pins(6'h04);
    sw.pulse(2, 1'b0); chk(32'(cmd.run), 32'h0); // stop
    sw.pulse(1, 1'b1); chk(run_rev, 32'h3); // reverse start
    sw.pulse(2, 1'b0); sw.pulse(0, 1'b1); chk(run_rev, 32'h2);
    wr(`DDI_OFS_CTRL, 32'h26); pins(6'h30);
    chk(run_rev, 32'h2); // forward only
    wr(`DDI_OFS_CTRL, 32'h27); chk(run_rev, 32'h3); // reverse
    wr(`DDI_OFS_CTRL, 32'h28); pins(6'h01); chk(32'(cmd.run), 32'h0); // pins ignored
    wr(`DDI_OFS_KEYPAD, 32'h1); chk(32'(cmd.run), 32'h1); // keypad run
    wr(`DDI_OFS_CTRL, 32'h29); wr(`DDI_OFS_KEYPAD, 32'hC);
    chk(run_rev, 32'h3); // serial run
    wr(`DDI_OFS_CTRL, 32'h02); pins(6'h03); chk(run_rev, 32'h2);
    wr(`DDI_OFS_CTRL, 32'h12); pins(6'h01); chk(run_rev, 32'h3);
    wr(`DDI_OFS_CTRL, 32'h2032); chk(32'({cmd.run, cmd.mod_reverse}), 32'h2);
    pins(6'h03); chk(32'({cmd.run, cmd.reverse, cmd.mod_reverse}), 32'h7); // fast
    wr(`DDI_OFS_CTRL, 32'h6032); pins(6'h01);
    chk(32'({cmd.run, cmd.reverse, cmd.mod_reverse}), 32'h5); // holds
    @(posedge core_clk); speed_zero <= 1'b1; repeat (2) @(negedge core_clk);
    chk(32'(cmd.mod_reverse), 32'h0); // at zero speed
    wr(`DDI_OFS_CTRL, 32'h00);
    for (int i = 0; i < 7; i++) begin
      wr(`DDI_OFS_CFG, {28'h0, cs_sel[i]}); pins(cs_pin[i]);
      chk(32'(cmd.const_speed), 32'(cs_exp[i])); // speed code
    end
    wr(`DDI_OFS_CFG, 32'hC0); pins(6'h04); chk(32'(cmd.ramp_set2), 32'h1);
    wr(`DDI_OFS_CFG, 32'hA00); pins(6'h10); chk(32'(cmd.param_lock), 32'h1);
    wr(`DDI_OFS_SCALE, 32'h00640010);
    chk(scale_now, 32'h01F40000); // locked
    pins(6'h00); wr(`DDI_OFS_SCALE, 32'h00640010);
    chk(scale_now, 32'h00640010); // open
    wr(`DDI_OFS_SCALE, 32'h00100020);
    chk(scale_now, 32'h00640010); // refused
    wr(`DDI_OFS_SCALE, 32'h00300030);
    chk(scale_now, 32'h00300030); // equal
    fault(); chk(32'(cmd.fault), 32'h1); // set
    wr(`DDI_OFS_CTRL, 32'h1000); pins(6'h08); chk(32'(cmd.fault), 32'h1); // rising
    pins(6'h00); chk(32'(cmd.fault), 32'h0); // falling clears
    wr(`DDI_OFS_CTRL, 32'h1C02); pins(6'h01); fault(); chk(32'(cmd.fault), 32'h1);
    pins(6'h00); chk(32'(cmd.fault), 32'h0); // stop clears
    wr(`DDI_OFS_CTRL, 32'h0182); pins(6'h01);
    chk(32'({cmd.run, cmd.coast_stop}), 32'h1); // coast
    pins(6'h21); chk(32'({cmd.run, cmd.coast_stop}), 32'h2); // permitted
    wr(`DDI_OFS_CTRL, 32'h02); pins(6'h00);
    wr(`DDI_OFS_POTLIM, 32'h00050000); wr(`DDI_OFS_RAMP, 32'h0); wr(`DDI_OFS_CFG, 32'h20);
    pins(6'h04); repeat (60) @(posedge core_clk); chk(32'(cmd.freq_ref), 32'h5); // up
    pins(6'h08); repeat (60) @(posedge core_clk); chk(32'(cmd.freq_ref), 32'h0); // down
    wr(`DDI_OFS_POTLIM, 32'h00050003); wr(`DDI_OFS_CFG, 32'h10);
    pins(6'h04); repeat (60) @(posedge core_clk); chk(32'(cmd.freq_ref), 32'h3);
    final_report();
  end
endmodule : tb
`default_nettype wire

// ### verilog/ddi_decoder.sv
// Drive digital input decoder with register port
//
// Operation
// R1 - DI1 level run, DI2 selects reverse
// R2 - DI1 pulse starts while DI2 high
// R3 - Pulse start/stop, DI3 level selects reverse
// R4 - DI1 forward, DI2 reverse, DI3 stops
// R5 - DI6 level run, forward only
// R6 - DI6 level run, DI5 selects reverse
// R7 - Keypad or serial source ignores inputs
// R8 - Motor pot up/down along set ramps
// R9 - Resetting pot returns to minimum when stopped
// R10 - Single input selects its constant speed
// R11 - Two inputs code constant speeds 1-3
// R12 - Three inputs code constant speeds 1-7
// R13 - Direction fixed forward, reverse, or requested
// R14 - Fast reverse with coast flips modulator
// R15 - Flying start disables fast reverse
// R16 - Falling reset input clears faults
// R17 - Reset on stop, serial, or none
// R18 - Ramp input picks time set 1/2
// R19 - Lock input high blocks parameter writes
// R20 - Refuse floor above ceiling
// R21 - Output selection writable only when stopped
// R22 - Run enable low coasts drive
// R23 - Run latch, stop wins over start
//
// The implementer's own choices: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "ddi_regs.svh"

module ddi_decoder #(
  parameter int POT_TICK_CYCLES = `DDI_POT_TICK_CYCLES
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [5:0] digital_input,
  input wire logic speed_zero,
  input wire logic fault_event,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output ddi_pkg::ddi_cmd_type cmd,
  output logic [7:0] output_select,
  output logic [15:0] reference_one_floor,
  output logic [15:0] reference_one_ceiling
);
  import ddi_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [5:0] sync1;
    logic [5:0] sync2;
    logic [5:0] prev;
    logic run_latch;
    logic dir_latch;
    logic src_run_prev;
    logic [15:0] tick_cnt;
    logic [7:0] pot_cnt;
    logic [31:0] rdata;
    ddi_ctrl_type ctrl;
    ddi_cfg_type cfg;
    ddi_keypad_type keypad;
    ddi_pair16_type scale;
    ddi_pair16_type potlim;
    ddi_ramp_type ramp;
    logic [31:0] outsel;
    ddi_cmd_type cmd;
  } ddi_state_type;

  ddi_state_type state; // Registered state
  ddi_state_type next_state; // Next value of every flop

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Level of the input chosen by a 1..6 selector, low otherwise
  function automatic logic di_pick(input logic [2:0] sel, input logic [5:0] di);
    logic bit_val;
    bit_val = 1'b0;
    if (sel != `DDI_SEL_NONE && sel != `DDI_SEL_SPECIAL) begin
      bit_val = di[sel - 3'h1];
    end
    return bit_val;
  endfunction : di_pick

  // Combinational decode values
  logic [5:0] di; // Synchronised input levels
  logic [5:0] rise; // Rising edges of the inputs
  logic [5:0] fall; // Falling edges of the inputs
  logic src_run; // Run request from the start/stop source
  logic src_rev; // Reverse request from the source
  logic req_rev; // Direction after the direction setting
  logic run_enable; // Run permission
  logic fast_rev; // Fast reverse active
  logic reset_now; // Fault reset event this cycle
  logic pot_up; // Motor pot raise level
  logic pot_down; // Motor pot lower level
  logic pot_tick; // Slow ramp tick
  logic [7:0] pot_rate; // Idle ticks before each step of the active ramp
  logic [2:0] cs_code; // Decoded constant speed
  logic locked; // Parameter writes blocked
  logic wr_ok; // Write to a lockable register allowed
  ddi_pair16_type scale_new; // Proposed scale write

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    di = state.sync2;
    rise = state.sync2 & ~state.prev;
    fall = state.prev & ~state.sync2;
    src_run = 1'b0;
    src_rev = 1'b0;
    scale_new = reg_wdata;

    // Two-flop synchroniser, then edge history
    next_state.sync1 = digital_input;
    next_state.sync2 = state.sync1;
    next_state.prev = state.sync2;

    // Run enable source
    if (state.ctrl.run_en_sel == `DDI_SEL_NONE) begin
      run_enable = 1'b1;
    end else if (state.ctrl.run_en_sel == `DDI_SEL_SPECIAL) begin
      run_enable = state.keypad.serial_run_enable;
    end else begin
      run_enable = di_pick(state.ctrl.run_en_sel, di);
    end

    // Start/stop decode per wiring mode
    next_state.run_latch = 1'b0;
    next_state.dir_latch = 1'b0;
    unique case (state.ctrl.start_mode)
      SS_DI1: begin
        src_run = di[0];
      end
      SS_DI1_2: begin
        // R1 level run and direction
        src_run = di[0];
        src_rev = di[1];
      end
      SS_TWO_PULSE, SS_PULSE_DIR: begin
        // R23 stop low clears before start sets
        if (!di[1] || !run_enable) begin
          next_state.run_latch = 1'b0;
        end else if (rise[0]) begin
          // R2 start only with stop held high
          next_state.run_latch = 1'b1;
        end else begin
          next_state.run_latch = state.run_latch;
        end
        src_run = state.run_latch;
        // R3 level direction on DI3
        src_rev = (state.ctrl.start_mode == SS_PULSE_DIR) ? di[2] : 1'b0;
      end
      SS_THREE_PULSE: begin
        // R4 separate forward and reverse starts
        next_state.dir_latch = state.dir_latch;
        if (!di[2] || !run_enable) begin
          next_state.run_latch = 1'b0;
        end else if (rise[0] || rise[1]) begin
          next_state.run_latch = 1'b1;
          next_state.dir_latch = rise[1] & ~rise[0];
        end else begin
          next_state.run_latch = state.run_latch;
        end
        src_run = state.run_latch;
        src_rev = state.dir_latch;
      end
      SS_DI6: begin
        // R5 level run, forward only
        src_run = di[5];
      end
      SS_DI6_5: begin
        // R6 level run, DI5 direction
        src_run = di[5];
        src_rev = di[4];
      end
      SS_KEYPAD: begin
        // R7 keypad source ignores inputs
        src_run = state.keypad.keypad_run;
        src_rev = state.keypad.keypad_rev;
      end
      SS_SERIAL: begin
        // R7 serial source ignores inputs
        src_run = state.keypad.serial_run;
        src_rev = state.keypad.serial_rev;
      end
      default: begin
        src_run = 1'b0;
      end
    endcase

    // R13 direction setting
    unique case (state.ctrl.dir)
      DIR_FORWARD: req_rev = 1'b0;
      DIR_REVERSE: req_rev = 1'b1;
      DIR_REQUEST, DIR_FAST_REV: req_rev = src_rev;
    endcase

    // R15 flying start cancels fast reverse
    fast_rev = (state.ctrl.dir == DIR_FAST_REV) && state.ctrl.stop_coast
      && !state.ctrl.start_flying;

    // R22 run enable gates run and coasts
    next_state.cmd.run = src_run & run_enable;
    next_state.cmd.coast_stop = ~run_enable;
    next_state.cmd.reverse = req_rev;
    // R14 modulator follows request at once in fast reverse, else only when stopped or at zero speed
    if (fast_rev || speed_zero || !state.cmd.run) begin
      next_state.cmd.mod_reverse = req_rev;
    end
    next_state.src_run_prev = src_run;

    // Fault reset sources
    reset_now = 1'b0;
    if (state.ctrl.reset_sel == `DDI_SEL_SPECIAL) begin
      // R17 stop command resets
      reset_now = state.src_run_prev & ~src_run;
    end else if (state.ctrl.reset_sel != `DDI_SEL_NONE) begin
      // R16 falling edge of chosen input
      reset_now = di_pick(state.ctrl.reset_sel, fall);
    end
    if (state.ctrl.reset_serial && reg_wr && reg_addr == `DDI_OFS_KEYPAD) begin
      // R17 serial link reset
      reset_now = reset_now | reg_wdata[`DDI_KEYPAD_RESET_BIT];
    end
    next_state.cmd.fault_reset = reset_now;
    // Fault flag: a new fault wins over a reset
    if (fault_event) begin
      next_state.cmd.fault = 1'b1;
    end else if (reset_now) begin
      next_state.cmd.fault = 1'b0;
    end

    // Constant speed decode
    cs_code = 3'h0;
    unique case (state.cfg.cs)
      CS_NONE: cs_code = 3'h0;
      CS_DI1, CS_DI2, CS_DI3, CS_DI4, CS_DI5, CS_DI6: begin
        // R10 one input, its own speed
        cs_code = di_pick(state.cfg.cs[2:0], di) ? state.cfg.cs[2:0] : 3'h0;
      end
      // R11 lower input is bit 0
      CS_PAIR12: cs_code = {1'b0, di[1], di[0]};
      CS_PAIR34: cs_code = {1'b0, di[3], di[2]};
      CS_PAIR56: cs_code = {1'b0, di[5], di[4]};
      // R12 lowest input is bit 0
      CS_TRI123: cs_code = di[2:0];
      CS_TRI345: cs_code = di[4:2];
      CS_TRI456: cs_code = di[5:3];
      default: cs_code = 3'h0;
    endcase
    next_state.cmd.const_speed = cs_code;

    // R18 ramp set input
    next_state.cmd.ramp_set2 = di_pick(state.cfg.ramp_sel, di);

    // R19 lock by input or keypad bit
    if (state.cfg.lock_sel == `DDI_SEL_NONE) begin
      locked = state.cfg.lock_keypad;
    end else begin
      locked = di_pick(state.cfg.lock_sel, di);
    end
    next_state.cmd.param_lock = locked;

    // Motor potentiometer tick divider
    pot_tick = (state.tick_cnt == 16'(POT_TICK_CYCLES - 1));
    next_state.tick_cnt = pot_tick ? 16'h0000 : state.tick_cnt + 16'h0001;
    pot_up = (state.cfg.pot == POT_DI56) ? di[4] : di[2];
    pot_down = (state.cfg.pot == POT_DI56) ? di[5] : di[3];
    if (state.cmd.ramp_set2) begin
      pot_rate = pot_up ? state.ramp.acc2 : state.ramp.dec2;
    end else begin
      pot_rate = pot_up ? state.ramp.acc1 : state.ramp.dec1;
    end
    if (state.cfg.pot == POT_DI34_RESET && !state.cmd.run) begin
      // R9 back to minimum while stopped
      next_state.cmd.freq_ref = state.potlim.floor;
      next_state.pot_cnt = 8'h00;
    end else if (state.cfg.pot != POT_NONE && pot_tick && (pot_up ^ pot_down)) begin
      // R8 step at the active ramp rate
      if (state.pot_cnt >= pot_rate) begin
        next_state.pot_cnt = 8'h00;
        if (pot_up && state.cmd.freq_ref < state.potlim.ceiling) begin
          next_state.cmd.freq_ref = state.cmd.freq_ref + 16'h0001;
        end else if (pot_down && state.cmd.freq_ref > state.potlim.floor) begin
          next_state.cmd.freq_ref = state.cmd.freq_ref - 16'h0001;
        end
      end else begin
        next_state.pot_cnt = state.pot_cnt + 8'h01;
      end
    end

    // Register writes
    wr_ok = reg_wr && !locked;
    if (wr_ok) begin
      unique case (reg_addr)
        `DDI_OFS_CTRL: begin
          next_state.ctrl = reg_wdata;
          next_state.ctrl.spare = '0;
        end
        `DDI_OFS_CFG: begin
          next_state.cfg = reg_wdata;
          next_state.cfg.spare = '0;
        end
        `DDI_OFS_SCALE: begin
          // R20 refuse floor above ceiling
          if (scale_new.floor <= scale_new.ceiling) begin
            next_state.scale = scale_new;
          end
        end
        `DDI_OFS_POTLIM: begin
          if (scale_new.floor <= scale_new.ceiling) begin
            next_state.potlim = scale_new;
          end
        end
        `DDI_OFS_RAMP: next_state.ramp = reg_wdata;
        `DDI_OFS_OUTSEL: begin
          // R21 only while stopped
          if (!state.cmd.run) begin
            next_state.outsel = {24'h000000, reg_wdata[7:0]};
          end
        end
        default: begin
          next_state.rdata = state.rdata;
        end
      endcase
    end
    // Keypad register stays writable so the lock can be lifted
    if (reg_wr && reg_addr == `DDI_OFS_KEYPAD) begin
      next_state.keypad = reg_wdata;
      next_state.keypad.spare = '0;
      if (state.cfg.lock_sel == `DDI_SEL_NONE) begin
        next_state.cfg.lock_keypad = reg_wdata[6];
      end
    end

    // Register reads, data in the following cycle
    next_state.rdata = 32'h00000000;
    if (reg_rd) begin
      unique case (reg_addr)
        `DDI_OFS_CTRL: next_state.rdata = state.ctrl;
        `DDI_OFS_CFG: next_state.rdata = state.cfg;
        `DDI_OFS_KEYPAD: next_state.rdata = state.keypad;
        `DDI_OFS_SCALE: next_state.rdata = state.scale;
        `DDI_OFS_POTLIM: next_state.rdata = state.potlim;
        `DDI_OFS_RAMP: next_state.rdata = state.ramp;
        `DDI_OFS_OUTSEL: next_state.rdata = state.outsel;
        `DDI_OFS_STATUS: begin
          next_state.rdata = {state.cmd.freq_ref, 6'h00, state.cmd.fault,
            state.cmd.param_lock, state.cmd.ramp_set2, state.cmd.const_speed,
            state.cmd.coast_stop, state.cmd.mod_reverse, state.cmd.reverse,
            state.cmd.run};
        end
        default: next_state.rdata = 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      state <= '0;
      state.ctrl <= `DDI_RST_CTRL;
      state.cfg <= `DDI_RST_CFG;
      state.keypad <= `DDI_RST_KEYPAD;
      state.scale <= `DDI_RST_SCALE;
      state.potlim <= `DDI_RST_POTLIM;
      state.ramp <= `DDI_RST_RAMP;
      state.outsel <= `DDI_RST_OUTSEL;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata = state.rdata;
  assign cmd = state.cmd;
  assign output_select = state.outsel[7:0];
  assign reference_one_floor = state.scale.floor;
  assign reference_one_ceiling = state.scale.ceiling;

endmodule : ddi_decoder
`default_nettype wire

// ### verilog/ddi_pkg.sv
// Types shared by the digital input decoder
`default_nettype none
package ddi_pkg;

  // ----------------------------------------------------------------
  // Mode encodings
  // ----------------------------------------------------------------
  // Start/stop source and wiring
  typedef enum logic [3:0] {
    SS_NONE = 4'h0,
    SS_DI1 = 4'h1,
    SS_DI1_2 = 4'h2,
    SS_TWO_PULSE = 4'h3,
    SS_PULSE_DIR = 4'h4,
    SS_THREE_PULSE = 4'h5,
    SS_DI6 = 4'h6,
    SS_DI6_5 = 4'h7,
    SS_KEYPAD = 4'h8,
    SS_SERIAL = 4'h9
  } ddi_start_mode_type;

  // Direction setting
  typedef enum logic [1:0] {
    DIR_FORWARD = 2'h0,
    DIR_REVERSE = 2'h1,
    DIR_REQUEST = 2'h2,
    DIR_FAST_REV = 2'h3
  } ddi_dir_type;

  // Constant speed input selection
  typedef enum logic [3:0] {
    CS_NONE = 4'h0,
    CS_DI1 = 4'h1,
    CS_DI2 = 4'h2,
    CS_DI3 = 4'h3,
    CS_DI4 = 4'h4,
    CS_DI5 = 4'h5,
    CS_DI6 = 4'h6,
    CS_PAIR12 = 4'h7,
    CS_PAIR34 = 4'h8,
    CS_PAIR56 = 4'h9,
    CS_TRI123 = 4'hA,
    CS_TRI345 = 4'hB,
    CS_TRI456 = 4'hC
  } ddi_cs_type;

  // Motor potentiometer input pair
  typedef enum logic [1:0] {
    POT_NONE = 2'h0,
    POT_DI34_RESET = 2'h1,
    POT_DI34 = 2'h2,
    POT_DI56 = 2'h3
  } ddi_pot_type;

  // ----------------------------------------------------------------
  // Register layouts
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [16:0] spare;
    logic start_flying;
    logic stop_coast;
    logic [2:0] reset_sel;
    logic reset_serial;
    logic [2:0] run_en_sel;
    ddi_dir_type dir;
    ddi_start_mode_type start_mode;
  } ddi_ctrl_type;

  typedef struct packed {
    logic [18:0] spare;
    logic lock_keypad;
    logic [2:0] lock_sel;
    logic [2:0] ramp_sel;
    ddi_pot_type pot;
    ddi_cs_type cs;
  } ddi_cfg_type;

  typedef struct packed {
    logic [26:0] spare;
    logic serial_run_enable;
    logic serial_rev;
    logic serial_run;
    logic keypad_rev;
    logic keypad_run;
  } ddi_keypad_type;

  typedef struct packed {
    logic [15:0] ceiling;
    logic [15:0] floor;
  } ddi_pair16_type;

  typedef struct packed {
    logic [7:0] dec2;
    logic [7:0] acc2;
    logic [7:0] dec1;
    logic [7:0] acc1;
  } ddi_ramp_type;

  // ----------------------------------------------------------------
  // Command bundle to the drive core
  // ----------------------------------------------------------------
  typedef struct packed {
    logic run;
    logic reverse;
    logic mod_reverse;
    logic coast_stop;
    logic ramp_set2;
    logic param_lock;
    logic fault_reset;
    logic fault;
    logic [2:0] const_speed;
    logic [15:0] freq_ref;
  } ddi_cmd_type;

endpackage : ddi_pkg
`default_nettype wire

// ### verilog/ddi_regs.svh
// Register offsets, reset values and timing counts of the digital input decoder
`ifndef DDI_REGS_SVH
`define DDI_REGS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define DDI_OFS_CTRL 8'h00
`define DDI_OFS_CFG 8'h04
`define DDI_OFS_KEYPAD 8'h08
`define DDI_OFS_SCALE 8'h0C
`define DDI_OFS_POTLIM 8'h10
`define DDI_OFS_RAMP 8'h14
`define DDI_OFS_OUTSEL 8'h18
`define DDI_OFS_STATUS 8'h1C

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
// Two-input level start/stop, direction on request
`define DDI_RST_CTRL 32'h00000022
`define DDI_RST_CFG 32'h00000000
`define DDI_RST_KEYPAD 32'h00000000
// Floor 0, ceiling 500
`define DDI_RST_SCALE 32'h01F40000
// Minimum 0, maximum 500
`define DDI_RST_POTLIM 32'h01F40000
// Every ramp step waits ten ticks
`define DDI_RST_RAMP 32'h0A0A0A0A
`define DDI_RST_OUTSEL 32'h00000000

// ----------------------------------------------------------------
// Field values and bit positions not carried by the structs
// ----------------------------------------------------------------
`define DDI_SEL_SPECIAL 3'h7
`define DDI_SEL_NONE 3'h0
`define DDI_KEYPAD_RESET_BIT 5

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define DDI_CLK_PERIOD_NS 25
// Motor potentiometer ramp tick, 1 ms
`define DDI_POT_TICK_NS 1000000
`define DDI_POT_TICK_CYCLES (`DDI_POT_TICK_NS / `DDI_CLK_PERIOD_NS)

`endif
